// *** tb/dps_priority_asserts.sv ***
// Checker of source precedence and bus timing for the parameter selector
`timescale 1ns/1ps
`default_nettype none
module dps_priority_asserts
	import dps_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic [dps_pkg::DPS_FREQ_W-1:0] ram_sample,
	input wire logic [dps_pkg::DPS_FREQ_W-1:0] ramp_generator_sample,
	input wire logic [dps_pkg::DPS_AMP_W-1:0] output_shift_keying_amp,
	input wire logic [dps_pkg::DPS_FREQ_W-1:0] frequency_tuning_word,
	input wire logic [dps_pkg::DPS_PHASE_W-1:0] phase_offset_word,
	input wire logic [dps_pkg::DPS_AMP_W-1:0] amplitude_scale_factor,
	input wire logic amp_scale_on
);
	// ==========================================================
	// Control shadow
	logic [31:0] ctl_reg;
	logic ram_on, ramp_on, key_on, key_man;
	logic [1:0] rdst, gdst;

	// Copy of the control word, taken on completed writes only
	always_ff @(posedge core_clk)
		if (sys_rst)
			ctl_reg <= '0;
		else if (avs_write && !avs_waitrequest && avs_address == DPS_OFF_CTRL)
			for (int i = 0; i < 4; i++)
				if (avs_byteenable[i])
					ctl_reg[8*i+:8] <= avs_writedata[8*i+:8];

	// Field decode
	assign ram_on = ctl_reg[DPS_CTRL_RAM_EN];
	assign rdst = ctl_reg[DPS_CTRL_RAM_DEST_LO+:2];
	assign ramp_on = ctl_reg[DPS_CTRL_RAMP_EN];
	assign gdst = ctl_reg[DPS_CTRL_RAMP_DEST_LO+:2];
	assign key_on = ctl_reg[DPS_CTRL_KEY_EN];
	assign key_man = ctl_reg[DPS_CTRL_KEY_MANUAL];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	sequence wait_pulse;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	bus_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> wait_pulse)
		else $error("bus access not done in one wait cycle");
	ram_freq_a: assert property (ram_on && rdst == RAM_DEST_FREQ |=> frequency_tuning_word == $past(ram_sample))
		else $error("frequency not from RAM");
	ram_phase_a: assert property (ram_on && rdst[0] |=> phase_offset_word == $past(ram_sample[31:16]))
		else $error("phase not from RAM");
	ramp_phase_a: assert property (!(ram_on && rdst[0]) && ramp_on && gdst == RAMP_DEST_PHASE
		|=> phase_offset_word == $past(ramp_generator_sample[31:16]))
		else $error("phase not from ramp");
	key_auto_a: assert property (key_on && !key_man
		|=> amp_scale_on && amplitude_scale_factor == $past(output_shift_keying_amp))
		else $error("amplitude not from shift keying");
	ram_amp_a: assert property (!key_on && ram_on && rdst == RAM_DEST_AMP
		|=> amplitude_scale_factor == $past(ram_sample[31:18]))
		else $error("amplitude not from RAM");
	ramp_amp_a: assert property (!key_on && !(ram_on && rdst[1]) && ramp_on && gdst == RAMP_DEST_AMP
		|=> amp_scale_on && amplitude_scale_factor == $past(ramp_generator_sample[31:18]))
		else $error("amplitude not from ramp");
	no_scale_a: assert property (!key_on && !(ram_on && rdst[1]) && !(ramp_on && gdst == RAMP_DEST_AMP)
		&& !ctl_reg[DPS_CTRL_PDP_EN] && !ctl_reg[DPS_CTRL_PROF_AMP_EN]
		|=> !amp_scale_on && amplitude_scale_factor == DPS_AMP_FULL)
		else $error("unclaimed amplitude not unscaled");
endmodule // dps_priority_asserts

bind dps_priority dps_priority_asserts u_chk (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .ram_sample, .ramp_generator_sample,
	.output_shift_keying_amp, .frequency_tuning_word, .phase_offset_word, .amplitude_scale_factor, .amp_scale_on);
`default_nettype wire

// *** tb/dps_priority_bench.sv ***
// Self-checking bench of the parameter source selector
`timescale 1ns/1ps
`default_nettype none
module dps_priority_bench;
	import dps_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0] avs_address = '0;
	logic [3:0] avs_byteenable = '0;
	logic [31:0] avs_writedata = '0, ram_sample = '0, ramp_generator_sample = '0;
	logic [13:0] output_shift_keying_amp = '0;
	logic [15:0] pd_word_pin = '0;
	logic [1:0] pd_dest_pin = '0;
	logic [31:0] avs_readdata, frequency_tuning_word;
	logic [15:0] phase_offset_word;
	logic [13:0] amplitude_scale_factor;
	logic avs_waitrequest, amp_scale_on;
	logic [31:0] rd_q[$];
	logic [62:0] out_q[$];
	int due_q[$];
	int bad_count = 0, num_checks = 0, cyc = 0;
	logic [31:0] rg[7];
	logic [31:0] msk[7] = '{32'h0, 32'h0, 32'hFFFF, 32'h3FFF, 32'hFFFF_FFFF, 32'hFFFF, 32'h3FFF};
	logic [62:0] ev, seen;
	logic [11:0] st;

	dps_priority uut (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .ram_sample, .ramp_generator_sample, .output_shift_keying_amp, .pd_word_pin,
		.pd_dest_pin, .frequency_tuning_word, .phase_offset_word, .amplitude_scale_factor, .amp_scale_on);

	// 50 MHz clock
	initial forever #10 core_clk = ~core_clk;

	// ==========================================================
	// Tasks
	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic fail(input string what, input logic [62:0] e, input logic [62:0] s);
		bad_count++;
		$display("BAD %s expected %h seen %h", what, e, s);
	endtask

	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		int n = 0;
		@(posedge core_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			bad_count++;
			stop_test();
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask

	// Expected outputs and status from controls, registers and sources
	function automatic void model();
		logic [31:0] c;
		logic [15:0] w;
		logic [1:0] d, r, g;
		logic [3:0] fs, ps, as;
		c = rg[0];
		w = pd_word_pin;
		d = pd_dest_pin;
		r = c[2:1];
		g = c[5:4];
		fs = (c[0] && r == 2'h0) ? 4'h0 : (c[3] && g == 2'h0) ? 4'h1 : (c[6] && d == 2'h2) ? 4'h2 : c[0] ? 4'h4 : 4'h5;
		ps = (c[0] && r[0]) ? 4'h0 : (c[3] && g == 2'h1) ? 4'h1 : (c[6] && d == 2'h1) ? 4'h2
			: (c[6] && d == 2'h3) ? 4'h3 : c[0] ? 4'h4 : 4'h5;
		as = (c[7] && !c[8]) ? 4'h6 : c[7] ? 4'h7 : (c[0] && r[1]) ? 4'h0 : (c[3] && g == 2'h2) ? 4'h1
			: (c[6] && d == 2'h0) ? 4'h2 : (c[6] && d == 2'h3) ? 4'h3 : c[9] ? 4'h5 : 4'h8;
		ev[62:31] = fs == 4'h0 ? ram_sample : fs == 4'h1 ? ramp_generator_sample
			: fs == 4'h2 ? rg[1] + ({16'h0, w} << c[15:12]) : fs == 4'h4 ? rg[1] : rg[4];
		ev[30:15] = ps == 4'h0 ? ram_sample[31:16] : ps == 4'h1 ? ramp_generator_sample[31:16] : ps == 4'h2 ? w
			: ps == 4'h3 ? {w[7:0], rg[2][7:0]} : ps == 4'h4 ? rg[2][15:0] : rg[5][15:0];
		ev[14:1] = as == 4'h6 ? output_shift_keying_amp : as == 4'h7 ? rg[3][13:0]
			: as == 4'h0 ? (r[0] ? ram_sample[15:2] : ram_sample[31:18]) : as == 4'h1 ? ramp_generator_sample[31:18]
			: as == 4'h2 ? w[15:2] : as == 4'h3 ? {w[15:8], rg[3][5:0]} : as == 4'h5 ? rg[6][13:0] : DPS_AMP_FULL;
		ev[0] = as != 4'h8;
		st = {as, ps, fs};
	endfunction

	// Compare each result with the oldest note
	always @(posedge core_clk) begin
		cyc++;
		if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
			num_checks++;
			if (avs_readdata !== rd_q[0])
				fail("readdata", rd_q[0], avs_readdata);
			void'(rd_q.pop_front());
		end
		if (due_q.size() > 0 && cyc >= due_q[0]) begin
			num_checks++;
			seen = {frequency_tuning_word, phase_offset_word, amplitude_scale_factor, amp_scale_on};
			if (seen !== out_q[0])
				fail("outputs", out_q[0], seen);
			void'(out_q.pop_front());
			void'(due_q.pop_front());
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(64569));
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		out_q.push_back({48'h0, DPS_AMP_FULL, 1'b0});
		due_q.push_back(cyc + 1);
		for (int k = 0; k < 7; k++)
			rd(5'(4 * k), 32'h0);
		rd(DPS_OFF_STATUS, 32'h0000_0855);
		bus(1'b1, DPS_OFF_FREQ, 32'hFFFF_FFFF, 4'b0101);
		rd(DPS_OFF_FREQ, 32'h00FF_00FF);
		for (int k = 2; k < 7; k++) begin
			bus(1'b1, 5'(4 * k), 32'hFFFF_FFFF, 4'hF);
			rd(5'(4 * k), msk[k]);
		end
		bus(1'b1, DPS_OFF_STATUS, 32'hFFFF_FFFF, 4'hF);
		rd(DPS_OFF_STATUS, 32'h0000_0855);
		rd(5'h1E, 32'h0);
		// Random controls, registers and sources
		for (int i = 0; i < 300; i++) begin
			@(posedge core_clk);
			ram_sample <= $urandom();
			ramp_generator_sample <= $urandom();
			output_shift_keying_amp <= 14'($urandom());
			pd_word_pin <= 16'($urandom());
			pd_dest_pin <= 2'($urandom());
			for (int k = 6; k >= 0; k--) begin
				rg[k] = $urandom() & (k == 0 ? 32'h0000_F3FF : 32'hFFFF_FFFF);
				bus(1'b1, 5'(4 * k), rg[k], 4'hF);
			end
			repeat (4) @(posedge core_clk);
			model();
			out_q.push_back(ev);
			due_q.push_back(cyc + 1);
			rd(DPS_OFF_STATUS, {20'h0, st});
			rd(DPS_OFF_CTRL, rg[0]);
		end
		// Let the watcher take the last notes, then none may be left
		repeat (3) @(posedge core_clk);
		if (rd_q.size() + out_q.size() != 0)
			fail("leftover notes", 63'h0, 63'(rd_q.size() + out_q.size()));
		stop_test();
	end
endmodule // dps_priority_bench
`default_nettype wire

// *** verilog/dps_fm_offset.sv ***
// Frequency word plus parallel-port offset scaled by the gain setting
`timescale 1ns/1ps
`default_nettype none
module dps_fm_offset
	import dps_pkg::*;
(
	input wire logic [dps_pkg::DPS_FREQ_W-1:0] base_word,
	input wire logic [dps_pkg::DPS_PD_W-1:0] port_word,
	input wire logic [3:0] gain,
	output logic [dps_pkg::DPS_FREQ_W-1:0] sum_word
);
	logic [DPS_FREQ_W-1:0] shifted;

	// ==========================================================
	// Gain zero keeps the port word LSB aligned
	always_comb begin
		shifted = {{(DPS_FREQ_W-DPS_PD_W){1'b0}}, port_word} << gain;
		sum_word = base_word + shifted;
	end
endmodule // dps_fm_offset
`default_nettype wire

// *** verilog/dps_pkg.sv ***
// Package of constants and types for the synthesizer parameter source selector
`default_nettype none
package dps_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [4:0] DPS_OFF_CTRL = 5'h00;
	localparam logic [4:0] DPS_OFF_FREQ = 5'h04;
	localparam logic [4:0] DPS_OFF_PHASE = 5'h08;
	localparam logic [4:0] DPS_OFF_AMP = 5'h0C;
	localparam logic [4:0] DPS_OFF_PROF_FREQ = 5'h10;
	localparam logic [4:0] DPS_OFF_PROF_PHASE = 5'h14;
	localparam logic [4:0] DPS_OFF_PROF_AMP = 5'h18;
	localparam logic [4:0] DPS_OFF_STATUS = 5'h1C;

	// ==========================================================
	// Control register field positions
	localparam int DPS_CTRL_RAM_EN = 0;
	localparam int DPS_CTRL_RAM_DEST_LO = 1;
	localparam int DPS_CTRL_RAMP_EN = 3;
	localparam int DPS_CTRL_RAMP_DEST_LO = 4;
	localparam int DPS_CTRL_PDP_EN = 6;
	localparam int DPS_CTRL_KEY_EN = 7;
	localparam int DPS_CTRL_KEY_MANUAL = 8;
	localparam int DPS_CTRL_PROF_AMP_EN = 9;
	localparam int DPS_CTRL_FM_GAIN_LO = 12;

	// ==========================================================
	// Reset values
	localparam logic [31:0] DPS_RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] DPS_RST_FREQ = 32'h0000_0000;
	localparam logic [15:0] DPS_RST_PHASE = 16'h0000;
	localparam logic [13:0] DPS_RST_AMP = 14'h0000;
	localparam logic [13:0] DPS_AMP_FULL = 14'h3FFF;

	// ==========================================================
	// Widths
	localparam int DPS_FREQ_W = 32;
	localparam int DPS_PHASE_W = 16;
	localparam int DPS_AMP_W = 14;
	localparam int DPS_PD_W = 16;

	// ==========================================================
	// Destination encodings
	typedef enum logic [1:0] {RAM_DEST_FREQ, RAM_DEST_PHASE, RAM_DEST_AMP, RAM_DEST_POLAR} dps_ram_dest_type;
	typedef enum logic [1:0] {RAMP_DEST_FREQ, RAMP_DEST_PHASE, RAMP_DEST_AMP, RAMP_DEST_OFF} dps_ramp_dest_type;
	typedef enum logic [1:0] {PDP_DEST_AMP, PDP_DEST_PHASE, PDP_DEST_FREQ, PDP_DEST_POLAR} dps_pdp_dest_type;

	// Chosen source of one parameter, reported in the status register
	typedef enum logic [3:0] {
		SRC_RAM, SRC_RAMP, SRC_PDP, SRC_PDP_CAT, SRC_REG, SRC_PROFILE,
		SRC_KEY_AUTO, SRC_KEY_MANUAL, SRC_NONE
	} dps_src_type;

	localparam int DPS_STAT_FREQ_LO = 0;
	localparam int DPS_STAT_PHASE_LO = 4;
	localparam int DPS_STAT_AMP_LO = 8;

endpackage
`default_nettype wire

// *** verilog/dps_priority.sv ***
// Source priority selector for synthesizer frequency, phase and amplitude
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dps_priority
	import dps_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Sources on the system clock
	input wire logic [dps_pkg::DPS_FREQ_W-1:0] ram_sample,
	input wire logic [dps_pkg::DPS_FREQ_W-1:0] ramp_generator_sample,
	input wire logic [dps_pkg::DPS_AMP_W-1:0] output_shift_keying_amp,
	// Parallel data port pins
	input wire logic [dps_pkg::DPS_PD_W-1:0] pd_word_pin,
	input wire logic [1:0] pd_dest_pin,
	// Parameters to the synthesizer core
	output logic [dps_pkg::DPS_FREQ_W-1:0] frequency_tuning_word,
	output logic [dps_pkg::DPS_PHASE_W-1:0] phase_offset_word,
	output logic [dps_pkg::DPS_AMP_W-1:0] amplitude_scale_factor,
	output logic amp_scale_on
);
	import dps_pkg::*;

	// ==========================================================
	// Registers
	logic [31:0] ctrl_reg;
	logic [31:0] freq_word_reg;
	logic [15:0] phase_word_reg;
	logic [13:0] amp_scale_reg;
	logic [31:0] prof_freq_reg;
	logic [15:0] prof_phase_reg;
	logic [13:0] prof_amp_reg;
	logic [31:0] rd_next;
	logic wr_take;
	logic [31:0] status_word;

	// Decoded controls
	logic ram_en, ramp_en, pdp_en, key_en, key_manual, prof_amp_en;
	dps_ram_dest_type ram_dest;
	dps_ramp_dest_type ramp_dest;
	dps_pdp_dest_type pdp_dest;
	logic [3:0] fm_gain;

	// Synchronised port pins
	logic [DPS_PD_W-1:0] pd_word;
	logic [1:0] pd_dest_bits;
	logic [DPS_FREQ_W-1:0] fm_sum;

	// Selection results
	logic [DPS_FREQ_W-1:0] freq_next;
	logic [DPS_PHASE_W-1:0] phase_next;
	logic [DPS_AMP_W-1:0] amp_next;
	logic scale_next;
	dps_src_type freq_src, phase_src, amp_src;

	// Byte-enable merge of a write into a word
	function automatic logic [31:0] merge_be(input logic [31:0] old_word, input logic [31:0] new_word,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ==========================================================
	// Pin inputs pass two flip-flops
	dps_sync2 #(.WIDTH(DPS_PD_W)) u_sync_word (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(pd_word_pin),
		.sync_out(pd_word)
	);

	dps_sync2 #(.WIDTH(2)) u_sync_dest (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(pd_dest_pin),
		.sync_out(pd_dest_bits)
	);

	// Frequency offset from the parallel port
	dps_fm_offset u_fm (
		.base_word(freq_word_reg),
		.port_word(pd_word),
		.gain(fm_gain),
		.sum_word(fm_sum)
	);

	// ==========================================================
	// Avalon handshake: one wait cycle, then the access completes
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	assign wr_take = avs_write && !avs_waitrequest;

	// Read data mux; unmapped addresses read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		unique case (avs_address)
			DPS_OFF_CTRL: rd_next = ctrl_reg;
			DPS_OFF_FREQ: rd_next = freq_word_reg;
			DPS_OFF_PHASE: rd_next = {16'h0000, phase_word_reg};
			DPS_OFF_AMP: rd_next = {18'h00000, amp_scale_reg};
			DPS_OFF_PROF_FREQ: rd_next = prof_freq_reg;
			DPS_OFF_PROF_PHASE: rd_next = {16'h0000, prof_phase_reg};
			DPS_OFF_PROF_AMP: rd_next = {18'h00000, prof_amp_reg};
			DPS_OFF_STATUS: rd_next = status_word;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	// Read data loaded as waitrequest falls
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_next;
		end
	end

	// Register writes at the completing edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg <= DPS_RST_CTRL;
			freq_word_reg <= DPS_RST_FREQ;
			phase_word_reg <= DPS_RST_PHASE;
			amp_scale_reg <= DPS_RST_AMP;
			prof_freq_reg <= DPS_RST_FREQ;
			prof_phase_reg <= DPS_RST_PHASE;
			prof_amp_reg <= DPS_RST_AMP;
		end else if (wr_take) begin
			unique case (avs_address)
				DPS_OFF_CTRL: ctrl_reg <= merge_be(ctrl_reg, avs_writedata, avs_byteenable);
				DPS_OFF_FREQ: freq_word_reg <= merge_be(freq_word_reg, avs_writedata, avs_byteenable);
				DPS_OFF_PHASE: phase_word_reg <=
					16'(merge_be({16'h0000, phase_word_reg}, avs_writedata, avs_byteenable));
				DPS_OFF_AMP: amp_scale_reg <=
					14'(merge_be({18'h00000, amp_scale_reg}, avs_writedata, avs_byteenable));
				DPS_OFF_PROF_FREQ: prof_freq_reg <= merge_be(prof_freq_reg, avs_writedata, avs_byteenable);
				DPS_OFF_PROF_PHASE: prof_phase_reg <=
					16'(merge_be({16'h0000, prof_phase_reg}, avs_writedata, avs_byteenable));
				DPS_OFF_PROF_AMP: prof_amp_reg <=
					14'(merge_be({18'h00000, prof_amp_reg}, avs_writedata, avs_byteenable));
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Independent enable bits and destinations
	always_comb begin
		ram_en = ctrl_reg[DPS_CTRL_RAM_EN];
		ram_dest = dps_ram_dest_type'(ctrl_reg[DPS_CTRL_RAM_DEST_LO +: 2]);
		ramp_en = ctrl_reg[DPS_CTRL_RAMP_EN];
		ramp_dest = dps_ramp_dest_type'(ctrl_reg[DPS_CTRL_RAMP_DEST_LO +: 2]);
		pdp_en = ctrl_reg[DPS_CTRL_PDP_EN];
		key_en = ctrl_reg[DPS_CTRL_KEY_EN];
		key_manual = ctrl_reg[DPS_CTRL_KEY_MANUAL];
		prof_amp_en = ctrl_reg[DPS_CTRL_PROF_AMP_EN];
		fm_gain = ctrl_reg[DPS_CTRL_FM_GAIN_LO +: 4];
		pdp_dest = dps_pdp_dest_type'(pd_dest_bits);
	end

	// ==========================================================
	// Frequency source, highest precedence first
	always_comb begin
		freq_next = prof_freq_reg;
		freq_src = SRC_PROFILE;
		if (ram_en && ram_dest == RAM_DEST_FREQ) begin
			freq_next = ram_sample;
			freq_src = SRC_RAM;
		end else if (ramp_en && ramp_dest == RAMP_DEST_FREQ) begin
			freq_next = ramp_generator_sample;
			freq_src = SRC_RAMP;
		end else if (pdp_en && pdp_dest == PDP_DEST_FREQ) begin
			freq_next = fm_sum;
			freq_src = SRC_PDP;
		end else if (ram_en) begin
			freq_next = freq_word_reg;
			freq_src = SRC_REG;
		end else if (ramp_en && (ramp_dest == RAMP_DEST_PHASE || ramp_dest == RAMP_DEST_AMP)) begin
			freq_next = prof_freq_reg;
			freq_src = SRC_PROFILE;
		end
	end

	// Phase source, highest precedence first
	always_comb begin
		phase_next = prof_phase_reg;
		phase_src = SRC_PROFILE;
		if (ram_en && (ram_dest == RAM_DEST_PHASE || ram_dest == RAM_DEST_POLAR)) begin
			phase_next = ram_sample[31:16];
			phase_src = SRC_RAM;
		end else if (ramp_en && ramp_dest == RAMP_DEST_PHASE) begin
			phase_next = ramp_generator_sample[31:16];
			phase_src = SRC_RAMP;
		end else if (pdp_en && pdp_dest == PDP_DEST_PHASE) begin
			phase_next = pd_word;
			phase_src = SRC_PDP;
		end else if (pdp_en && pdp_dest == PDP_DEST_POLAR) begin
			phase_next = {pd_word[7:0], phase_word_reg[7:0]};
			phase_src = SRC_PDP_CAT;
		end else if (ram_en) begin
			phase_next = phase_word_reg;
			phase_src = SRC_REG;
		end
	end

	// Amplitude source, highest precedence first
	always_comb begin
		amp_next = DPS_AMP_FULL;
		scale_next = 1'b0;
		amp_src = SRC_NONE;
		if (key_en && !key_manual) begin
			amp_next = output_shift_keying_amp;
			scale_next = 1'b1;
			amp_src = SRC_KEY_AUTO;
		end else if (key_en) begin
			amp_next = amp_scale_reg;
			scale_next = 1'b1;
			amp_src = SRC_KEY_MANUAL;
		end else if (ram_en && ram_dest == RAM_DEST_AMP) begin
			amp_next = ram_sample[31:18];
			scale_next = 1'b1;
			amp_src = SRC_RAM;
		end else if (ram_en && ram_dest == RAM_DEST_POLAR) begin
			amp_next = ram_sample[15:2];
			scale_next = 1'b1;
			amp_src = SRC_RAM;
		end else if (ramp_en && ramp_dest == RAMP_DEST_AMP) begin
			amp_next = ramp_generator_sample[31:18];
			scale_next = 1'b1;
			amp_src = SRC_RAMP;
		end else if (pdp_en && pdp_dest == PDP_DEST_AMP) begin
			amp_next = pd_word[15:2];
			scale_next = 1'b1;
			amp_src = SRC_PDP;
		end else if (pdp_en && pdp_dest == PDP_DEST_POLAR) begin
			amp_next = {pd_word[15:8], amp_scale_reg[5:0]};
			scale_next = 1'b1;
			amp_src = SRC_PDP_CAT;
		end else if (prof_amp_en) begin
			amp_next = prof_amp_reg;
			scale_next = 1'b1;
			amp_src = SRC_PROFILE;
		end
	end

	// Status word shows the chosen sources
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[DPS_STAT_FREQ_LO +: 4] = freq_src;
		status_word[DPS_STAT_PHASE_LO +: 4] = phase_src;
		status_word[DPS_STAT_AMP_LO +: 4] = amp_src;
	end

	// ==========================================================
	// Parameter outputs registered once
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			frequency_tuning_word <= DPS_RST_FREQ;
			phase_offset_word <= DPS_RST_PHASE;
			amplitude_scale_factor <= DPS_AMP_FULL;
			amp_scale_on <= 1'b0;
		end else begin
			frequency_tuning_word <= freq_next;
			phase_offset_word <= phase_next;
			amplitude_scale_factor <= amp_next;
			amp_scale_on <= scale_next;
		end
	end

endmodule // dps_priority
`default_nettype wire

// *** verilog/dps_sync2.sv ***
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dps_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// ==========================================================
	// First stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // dps_sync2
`default_nettype wire
